// File: logic/ccr_map.vh
// offsets, field positions and reset values of the clock ratio block
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

// register byte offsets
`define CCR_OFS_UNIT_CLK 12'h000
`define CCR_OFS_LBCCR 12'h004
`define CCR_OFS_RATIO 12'h008
`define CCR_OFS_STRAP 12'h00C

// reset configuration word low layout
`define CCR_RCW_LBCM_BIT 31
`define CCR_RCW_MEMMODE_BIT 30
`define CCR_RCW_MCODE_HI 27
`define CCR_RCW_MCODE_LO 24
`define CCR_RCW_CORE_HI 22
`define CCR_RCW_CORE_LO 16

// system multiplier codes
`define CCR_MCODE_X16 4'h0
`define CCR_MCODE_RSVD 4'h1
`define CCR_MULT_X16 8'h10

// hard-coded reset option word
`define CCR_RCW_HARD 32'h0404_0000

// unit clock select codes, two bits per unit
`define CCR_UCLK_OFF 2'h0
`define CCR_UCLK_FULL 2'h1
`define CCR_UCLK_HALF 2'h2
`define CCR_UCLK_THIRD 2'h3
`define CCR_UNITS 5
`define CCR_PCI_UNIT 4
`define CCR_UNIT_CLK_RST 10'h1FF

// local bus clock configuration register
`define CCR_LBDIV_HI 3
`define CCR_LBDIV_LO 0
`define CCR_LBDIV_RST 4'h2
`define CCR_LBDIV_MIN 4'h2

// ratio status register layout
`define CCR_RAT_CSB_LO 0
`define CCR_RAT_MEM_LO 8
`define CCR_RAT_PRI_LO 16
`define CCR_RAT_RSVD_BIT 24
`define CCR_RAT_VALID_BIT 25
`define CCR_RAT_HOST_BIT 26

// strap capture waits this many cycles after reset release
`define CCR_CAP_WAIT 3'h4

`endif

// File: logic/ccr_clk_div.v
// integer tick divider with a square clock output
`timescale 1ns/100ps
`default_nettype none

module ccr_clk_div (
    input wire sys_clk, // block clock
    input wire rst, // asynchronous reset, active high
    input wire tick_in, // source clock tick, one cycle
    input wire [1:0] ratio, // 0 off, else divide by ratio
    output reg tick_out_q, // divided tick, one cycle
    output reg clk_out_q // toggles on each divided tick
);

    reg [1:0] cnt_q;
    wire last;

    assign last = (cnt_q == ratio - 2'h1);

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 2'h0;
            tick_out_q <= 1'b0;
            clk_out_q <= 1'b0;
        end else if (ratio == 2'h0) begin
            // off: the output parks low and stays quiet
            cnt_q <= 2'h0;
            tick_out_q <= 1'b0;
            clk_out_q <= 1'b0;
        end else begin
            tick_out_q <= tick_in & last;
            if (tick_in) begin
                cnt_q <= last ? 2'h0 : cnt_q + 2'h1;
                if (last) begin
                    clk_out_q <= ~clk_out_q;
                end
            end
        end
    end

endmodule

`default_nettype wire

// File: logic/ccr_top.v
// clock ratio selection, derived clock ticks and unit clock control
`timescale 1ns/100ps
`default_nettype none
`include "ccr_map.vh"

// What this block does
// RQ1: csb ratio is predivide term times multiplier
// RQ2: host mode: predivide product is primary input
// RQ3: multiplier code 0 is sixteen, 1 reserved
// RQ4: multiplier fields come from captured low word
// RQ5: memory clock is csb times one plus mode
// RQ6: memory bus clock is memory clock halved
// RQ7: local bus clock mode then register divider
// RQ8: unit clocks software set, documented defaults
// RQ9: sync out and test out driven in reset
// RQ10: captured ratios held; reserved code gives none
module ccr_top (
    input wire sys_clk, // twice the csb clock rate
    input wire rst, // asynchronous reset, active high
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, high for write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output wire pready, // apb ready
    output wire pslverr, // apb error on unmapped address
    input wire [31:0] reset_config_word_low, // strap word pins
    input wire hard_reset_option_pin, // use the hard-coded word
    input wire input_clock_predivide_pin, // predivide configuration pin
    input wire pci_host_mode_pin, // device acts as pci host
    input wire core_tdo, // test data from the scan logic
    output reg [7:0] csb_ratio, // csb over pci sync input
    output reg [7:0] primary_ratio, // csb over primary clock input
    output reg [7:0] memory_ratio, // memory clock over pci sync input
    output reg [6:0] core_pll_ratio_field, // core multiplier selection
    output reg clocks_valid, // ratios captured and legal
    output reg mult_reserved, // reserved multiplier code seen
    output wire csb_tick, // one cycle per csb clock
    output wire memory_clk_tick, // one cycle per memory clock
    output wire local_bus_unit_tick, // one cycle per lbiu clock
    output reg memory_bus_clock_out, // memory bus clock, true
    output reg memory_bus_clock_out_n, // memory bus clock, complement
    output reg [2:0] local_bus_clock_out, // local bus clocks
    output reg local_bus_sync_out, // local bus sync clock
    output wire [4:0] unit_clk_tick, // per unit clock ticks
    output reg pci_sync_out, // pci sync clock out
    output wire pci_sync_out_oe_n, // pci sync output enable, low drives
    output reg tdo, // test data out
    output wire tdo_oe_n // test data output enable, low drives
);

    localparam ST_WAIT = 3'b001;
    localparam ST_CAPT = 3'b010;
    localparam ST_RUN = 3'b100;

    // strap synchronisers, three stages
    reg [31:0] rcw_s1_q, rcw_s2_q, rcw_s3_q;
    reg [2:0] opt_s1_q, opt_s2_q, opt_s3_q;
    reg [2:0] state_q, state_d;
    reg [2:0] wait_q;
    reg [31:0] strap_q;
    reg div_q, host_q;
    reg csb_ph_q;
    reg [9:0] unit_clk_q;
    reg [3:0] lbdiv_q;
    reg [3:0] lb_cnt_q;
    reg [7:0] mult;
    wire [3:0] mcode;
    wire run;
    wire [3:0] lbdiv_eff;
    wire ddr_tick_out;
    wire wr_en, rd_setup;
    reg hit;
    reg [31:0] rd_val;

    function [7:0] mcode_mult;
        input [3:0] code;
        begin
            case (code)
                `CCR_MCODE_X16: mcode_mult = `CCR_MULT_X16;
                `CCR_MCODE_RSVD: mcode_mult = 8'h00;
                default: mcode_mult = {4'h0, code};
            endcase
        end
    endfunction

    function addr_mapped;
        input [11:0] a;
        begin
            addr_mapped = (a == `CCR_OFS_UNIT_CLK) || (a == `CCR_OFS_LBCCR) ||
                (a == `CCR_OFS_RATIO) || (a == `CCR_OFS_STRAP);
        end
    endfunction

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rcw_s1_q <= 32'h0000_0000;
            rcw_s2_q <= 32'h0000_0000;
            rcw_s3_q <= 32'h0000_0000;
            opt_s1_q <= 3'h0;
            opt_s2_q <= 3'h0;
            opt_s3_q <= 3'h0;
        end else begin
            rcw_s1_q <= reset_config_word_low;
            rcw_s2_q <= rcw_s1_q;
            rcw_s3_q <= rcw_s2_q;
            opt_s1_q <= {pci_host_mode_pin, hard_reset_option_pin, input_clock_predivide_pin};
            opt_s2_q <= opt_s1_q;
            opt_s3_q <= opt_s2_q;
        end
    end

    // capture waits for the pipes to fill and the last two stages to agree
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_WAIT: begin
                if (wait_q == `CCR_CAP_WAIT) begin
                    state_d = ST_CAPT;
                end
            end
            ST_CAPT: begin
                if ((rcw_s2_q == rcw_s3_q) && (opt_s2_q == opt_s3_q)) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_WAIT;
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_WAIT;
            wait_q <= 3'h0;
            strap_q <= 32'h0000_0000;
            div_q <= 1'b0;
            host_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_WAIT) begin
                wait_q <= wait_q + 3'h1;
            end
            // taken once; nothing but a reset replaces it
            if ((state_q == ST_CAPT) && (state_d == ST_RUN)) begin // RQ10
                strap_q <= opt_s3_q[1] ? `CCR_RCW_HARD : rcw_s3_q; // RQ4
                div_q <= opt_s3_q[0];
                host_q <= opt_s3_q[2];
            end
        end
    end

    assign run = (state_q == ST_RUN);
    assign mcode = strap_q[`CCR_RCW_MCODE_HI:`CCR_RCW_MCODE_LO];

    always @* begin
        mult = mcode_mult(mcode); // RQ3
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            csb_ratio <= 8'h00;
            primary_ratio <= 8'h00;
            memory_ratio <= 8'h00;
            core_pll_ratio_field <= 7'h00;
            clocks_valid <= 1'b0;
            mult_reserved <= 1'b0;
        end else begin
            csb_ratio <= div_q ? {mult[6:0], 1'b0} : mult; // RQ1
            // host: the predivided sync input is the primary clock
            primary_ratio <= host_q ? mult : (div_q ? {mult[6:0], 1'b0} : mult); // RQ2
            memory_ratio <= (div_q ? {mult[6:0], 1'b0} : mult) <<
                strap_q[`CCR_RCW_MEMMODE_BIT]; // RQ5
            core_pll_ratio_field <= strap_q[`CCR_RCW_CORE_HI:`CCR_RCW_CORE_LO]; // RQ4
            mult_reserved <= run & (mcode == `CCR_MCODE_RSVD); // RQ3
            clocks_valid <= run & (mcode != `CCR_MCODE_RSVD); // RQ10
        end
    end

    // sys_clk runs at twice csb so a doubled memory or lbiu clock fits
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            csb_ph_q <= 1'b0;
        end else begin
            csb_ph_q <= clocks_valid ? ~csb_ph_q : 1'b0;
        end
    end

    assign csb_tick = clocks_valid & csb_ph_q;
    assign memory_clk_tick = clocks_valid &
        (strap_q[`CCR_RCW_MEMMODE_BIT] | csb_ph_q); // RQ5
    assign local_bus_unit_tick = clocks_valid &
        (strap_q[`CCR_RCW_LBCM_BIT] | csb_ph_q); // RQ7

    ccr_clk_div u_mem_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick_in(memory_clk_tick),
        .ratio(2'h1),
        .tick_out_q(),
        .clk_out_q(ddr_tick_out)
    );

    // toggling once per memory clock halves it
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            memory_bus_clock_out <= 1'b0;
            memory_bus_clock_out_n <= 1'b1;
        end else begin
            memory_bus_clock_out <= ddr_tick_out; // RQ6
            memory_bus_clock_out_n <= ~ddr_tick_out; // RQ6
        end
    end

    // divider below two cannot make a square wave, so it is clamped
    assign lbdiv_eff = (lbdiv_q < `CCR_LBDIV_MIN) ? `CCR_LBDIV_MIN : lbdiv_q;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lb_cnt_q <= 4'h0;
            local_bus_clock_out <= 3'h0;
            local_bus_sync_out <= 1'b0;
        end else begin
            if (local_bus_unit_tick) begin
                lb_cnt_q <= (lb_cnt_q >= lbdiv_eff - 4'h1) ? 4'h0 : lb_cnt_q + 4'h1; // RQ7
            end
            local_bus_clock_out <= {3{clocks_valid & (lb_cnt_q < {1'b0, lbdiv_eff[3:1]})}};
            local_bus_sync_out <= clocks_valid & (lb_cnt_q < {1'b0, lbdiv_eff[3:1]}); // RQ7
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `CCR_UNITS; gi = gi + 1) begin : g_unit
            ccr_clk_div u_div (
                .sys_clk(sys_clk),
                .rst(rst),
                .tick_in(csb_tick),
                .ratio(unit_clk_q[2*gi+1:2*gi]), // RQ8
                .tick_out_q(unit_clk_tick[gi]),
                .clk_out_q()
            );
        end
    endgenerate

    // driven from reset onward; the enables never release the pins
    assign pci_sync_out_oe_n = 1'b0; // RQ9
    assign tdo_oe_n = 1'b0; // RQ9

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pci_sync_out <= 1'b0;
            tdo <= 1'b0;
        end else begin
            pci_sync_out <= csb_ph_q; // RQ9
            tdo <= core_tdo;
        end
    end

    // apb slave, zero wait states
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~hit;
    assign wr_en = psel & penable & pwrite & hit;
    assign rd_setup = psel & ~penable;

    always @* begin
        hit = addr_mapped(paddr);
        rd_val = 32'h0000_0000;
        case (paddr)
            `CCR_OFS_UNIT_CLK: rd_val = {22'h00_0000, unit_clk_q};
            `CCR_OFS_LBCCR: rd_val = {28'h000_0000, lbdiv_q};
            `CCR_OFS_RATIO: begin
                rd_val[`CCR_RAT_CSB_LO +: 8] = csb_ratio;
                rd_val[`CCR_RAT_MEM_LO +: 8] = memory_ratio;
                rd_val[`CCR_RAT_PRI_LO +: 8] = primary_ratio;
                rd_val[`CCR_RAT_RSVD_BIT] = mult_reserved;
                rd_val[`CCR_RAT_VALID_BIT] = clocks_valid;
                rd_val[`CCR_RAT_HOST_BIT] = host_q;
            end
            `CCR_OFS_STRAP: rd_val = strap_q;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            unit_clk_q <= `CCR_UNIT_CLK_RST; // RQ8
            lbdiv_q <= `CCR_LBDIV_RST;
        end else begin
            if (rd_setup) begin
                prdata <= rd_val;
            end
            if (wr_en && (paddr == `CCR_OFS_UNIT_CLK)) begin
                unit_clk_q[7:0] <= pwdata[7:0]; // RQ8
                // pci and dma complex knows only off or full
                unit_clk_q[9:8] <= (pwdata[9:8] == `CCR_UCLK_OFF) ?
                    `CCR_UCLK_OFF : `CCR_UCLK_FULL; // RQ8
            end
            if (wr_en && (paddr == `CCR_OFS_LBCCR)) begin
                lbdiv_q <= pwdata[`CCR_LBDIV_HI:`CCR_LBDIV_LO]; // RQ7
            end
        end
    end

endmodule

`default_nettype wire

// File: tb/ccr_props.sv
// concurrent checks on the clock ratio block ports
`timescale 1ns/100ps
`default_nettype none
module ccr_props (
    input wire logic sys_clk, // clock
    input wire logic rst, // reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic [11:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic core_tdo, // test data in
    input wire logic tdo, // test data out
    input wire logic tdo_oe_n, // tdo enable
    input wire logic pci_sync_out_oe_n, // sync out enable
    input wire logic [7:0] csb_ratio, // csb ratio
    input wire logic [7:0] memory_ratio, // memory ratio
    input wire logic clocks_valid, // ratios legal
    input wire logic mult_reserved, // reserved code
    input wire logic csb_tick, // csb tick
    input wire logic memory_clk_tick, // memory tick
    input wire logic local_bus_unit_tick, // lbiu tick
    input wire logic memory_bus_clock_out, // memory bus clock
    input wire logic memory_bus_clock_out_n, // its complement
    input wire logic [2:0] local_bus_clock_out, // local bus clocks
    input wire logic local_bus_sync_out, // local bus sync clock
    input wire logic pci_sync_out // pci sync clock out
);
    sequence s_csb_gap;
        !csb_tick ##1 csb_tick;
    endsequence
    property p_csb_period;
        @(posedge sys_clk) disable iff (rst) csb_tick |=> s_csb_gap;
    endproperty
    a_csb_period: assert property (p_csb_period) else $error("csb tick spacing wrong");
    property p_tick_sub;
        @(posedge sys_clk) disable iff (rst) csb_tick |-> memory_clk_tick && local_bus_unit_tick;
    endproperty
    a_tick_sub: assert property (p_tick_sub) else $error("derived tick missing");
    property p_mem_ratio;
        @(posedge sys_clk) disable iff (rst)
            clocks_valid |-> (memory_ratio == csb_ratio || memory_ratio == {csb_ratio[6:0], 1'b0});
    endproperty
    a_mem_ratio: assert property (p_mem_ratio) else $error("memory ratio wrong");
    property p_mck_pair;
        @(posedge sys_clk) disable iff (rst) memory_bus_clock_out_n == !memory_bus_clock_out;
    endproperty
    a_mck_pair: assert property (p_mck_pair) else $error("memory bus clock pair unbalanced");
    property p_mck_toggle;
        @(posedge sys_clk) disable iff (rst)
            memory_bus_clock_out != $past(memory_bus_clock_out) |-> $past(memory_clk_tick, 2);
    endproperty
    a_mck_toggle: assert property (p_mck_toggle) else $error("memory bus clock toggled untimely");
    property p_rsvd_quiet;
        @(posedge sys_clk) disable iff (rst)
            mult_reserved |-> !csb_tick && !memory_clk_tick && !local_bus_unit_tick && !clocks_valid;
    endproperty
    a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("clock runs on reserved code");
    property p_held;
        @(posedge sys_clk) disable iff (rst)
            clocks_valid && $past(clocks_valid) |-> $stable(csb_ratio) && $stable(memory_ratio);
    endproperty
    a_held: assert property (p_held) else $error("captured ratio changed");
    // enables are checked through reset on purpose
    property p_oe_low;
        @(posedge sys_clk) tdo_oe_n == 1'b0 && pci_sync_out_oe_n == 1'b0;
    endproperty
    a_oe_low: assert property (p_oe_low) else $error("output not driven");
    property p_tdo_follow;
        @(posedge sys_clk) disable iff (rst) !$past(rst) |-> tdo == $past(core_tdo);
    endproperty
    a_tdo_follow: assert property (p_tdo_follow) else $error("tdo does not follow");
    property p_apb_ready;
        @(posedge sys_clk) disable iff (rst)
            psel && penable |-> pready &&
                (pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}));
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb answer wrong");
    property p_local_bus_clock_out_copy;
        @(posedge sys_clk) disable iff (rst) local_bus_clock_out == {3{local_bus_sync_out}};
    endproperty
    a_local_bus_clock_out_copy: assert property (p_local_bus_clock_out_copy) else $error("local bus clocks differ");
    property p_pci_sync;
        @(posedge sys_clk) disable iff (rst) csb_tick |=> pci_sync_out;
    endproperty
    a_pci_sync: assert property (p_pci_sync) else $error("pci sync out not running");
endmodule
`default_nettype wire

// File: tb/ccr_unit_sink.sv
// model of the units fed by the derived clocks: counts what they receive
`timescale 1ns/100ps
`default_nettype none
module ccr_unit_sink (
    input wire logic sys_clk, // clock
    input wire logic clr, // restart the counts
    input wire logic csb_tick, // csb tick
    input wire logic [4:0] unit_clk_tick, // unit ticks
    input wire logic local_bus_sync_out, // local bus sync clock
    input wire logic memory_bus_clock_out, // memory bus clock
    output logic [15:0] n_csb, // csb ticks seen
    output logic [79:0] n_unit, // five unit counts
    output logic [15:0] n_lsync, // sync clock rises
    output logic [15:0] n_mck // memory clock rises
);
    logic lsync_q;
    logic mck_q;
    always @(posedge sys_clk) begin
        lsync_q <= local_bus_sync_out;
        mck_q <= memory_bus_clock_out;
        if (clr) begin
            n_csb <= 16'h0000;
            n_unit <= 80'h0;
            n_lsync <= 16'h0000;
            n_mck <= 16'h0000;
        end else begin
            n_csb <= n_csb + 16'(csb_tick);
            for (int k = 0; k < 5; k++) begin
                n_unit[k*16 +: 16] <= n_unit[k*16 +: 16] + 16'(unit_clk_tick[k]);
            end
            n_lsync <= n_lsync + 16'(local_bus_sync_out & ~lsync_q);
            n_mck <= n_mck + 16'(memory_bus_clock_out & ~mck_q);
        end
    end
endmodule
`default_nettype wire

// File: tb/ccr_tb_top.sv
// self-checking bench for the clock ratio block
`timescale 1ns/100ps
`default_nettype none
`include "ccr_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module tb_top;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, clr, er, core_tdo;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, reset_config_word_low, rd;
    logic hard_reset_option_pin, input_clock_predivide_pin, pci_host_mode_pin;
    logic [7:0] csb_ratio, primary_ratio, memory_ratio;
    logic [6:0] core_pll_ratio_field;
    logic clocks_valid, mult_reserved, csb_tick, memory_clk_tick, local_bus_unit_tick;
    logic memory_bus_clock_out, memory_bus_clock_out_n, local_bus_sync_out, pci_sync_out;
    logic pci_sync_out_oe_n, tdo, tdo_oe_n;
    logic [2:0] local_bus_clock_out;
    logic [4:0] unit_clk_tick;
    logic [15:0] n_csb, n_lsync, n_mck;
    logic [79:0] n_unit;
    int failures = 0;
    int n_compared = 0;
    logic [3:0] t_mcode [5] = '{4'h3, 4'h0, 4'hF, 4'h1, 4'h9};
    logic [4:0] t_ddr = 5'b00101;
    logic [4:0] t_lb = 5'b00110;
    logic [4:0] t_div = 5'b10011;
    logic [4:0] t_host = 5'b00010;
    logic [4:0] t_hard = 5'b10000;
    ccr_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_config_word_low(reset_config_word_low),
        .hard_reset_option_pin(hard_reset_option_pin),
        .input_clock_predivide_pin(input_clock_predivide_pin),
        .pci_host_mode_pin(pci_host_mode_pin), .core_tdo(core_tdo), .csb_ratio(csb_ratio),
        .primary_ratio(primary_ratio), .memory_ratio(memory_ratio),
        .core_pll_ratio_field(core_pll_ratio_field), .clocks_valid(clocks_valid),
        .mult_reserved(mult_reserved), .csb_tick(csb_tick), .memory_clk_tick(memory_clk_tick),
        .local_bus_unit_tick(local_bus_unit_tick), .memory_bus_clock_out(memory_bus_clock_out),
        .memory_bus_clock_out_n(memory_bus_clock_out_n),
        .local_bus_clock_out(local_bus_clock_out), .local_bus_sync_out(local_bus_sync_out),
        .unit_clk_tick(unit_clk_tick), .pci_sync_out(pci_sync_out),
        .pci_sync_out_oe_n(pci_sync_out_oe_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
    ccr_unit_sink sink (.sys_clk(sys_clk), .clr(clr), .csb_tick(csb_tick),
        .unit_clk_tick(unit_clk_tick), .local_bus_sync_out(local_bus_sync_out),
        .memory_bus_clock_out(memory_bus_clock_out), .n_csb(n_csb), .n_unit(n_unit),
        .n_lsync(n_lsync), .n_mck(n_mck));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) core_tdo <= ~core_tdo;
    task finish_test;
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // window of 120 cycles is a multiple of every period used here
    task counts(input logic [15:0] c, input logic [79:0] u, input logic [15:0] ls,
                input logic [15:0] mk);
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (120) @(posedge sys_clk);
        #1;
        `CHK(n_csb, c);
        `CHK(n_unit, u);
        `CHK(n_lsync, ls);
        `CHK(n_mck, mk);
    endtask
    task run_strap(input int i);
        logic [31:0] word, eff;
        logic [7:0] mult, e_csb, e_mem, e_pri;
        logic rsvd;
        word = {t_lb[i], t_ddr[i], 2'b00, t_mcode[i], 1'b0, 7'h11 + 7'(i), 16'h0000};
        eff = t_hard[i] ? `CCR_RCW_HARD : word;
        mult = (eff[27:24] == 4'h0) ? 8'h10 : {4'h0, eff[27:24]};
        e_csb = mult << t_div[i];
        e_mem = e_csb << eff[30];
        e_pri = t_host[i] ? mult : e_csb;
        rsvd = (eff[27:24] == 4'h1);
        @(posedge sys_clk);
        rst <= 1'b1;
        reset_config_word_low <= word;
        hard_reset_option_pin <= t_hard[i];
        input_clock_predivide_pin <= t_div[i];
        pci_host_mode_pin <= t_host[i];
        repeat (5) @(posedge sys_clk);
        `CHK({pci_sync_out_oe_n, tdo_oe_n, memory_bus_clock_out_n, pci_sync_out, tdo}, 5'b00100);
        rst <= 1'b0;
        while (clocks_valid !== 1'b1 && mult_reserved !== 1'b1) @(posedge sys_clk);
        repeat (8) @(posedge sys_clk);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHK(rd, eff);
        `CHK(core_pll_ratio_field, eff[22:16]);
        // strap pins moving after capture must not disturb anything
        reset_config_word_low <= ~word;
        input_clock_predivide_pin <= ~t_div[i];
        hard_reset_option_pin <= ~t_hard[i];
        pci_host_mode_pin <= ~t_host[i];
        apb(1'b0, 12'h008, 32'h0000_0000);
        if (rsvd) begin
            `CHK({mult_reserved, clocks_valid, rd[25:24]}, 4'b1001);
            counts(16'h0000, 80'h0, 16'h0000, 16'h0000);
            return;
        end
        `CHK(rd[26:0], {t_host[i], 1'b1, 1'b0, e_pri, e_mem, e_csb});
        `CHK(csb_ratio, e_csb);
        `CHK(primary_ratio, e_pri);
        `CHK(memory_ratio, e_mem);
        counts(16'h003C, {16'h003C, {4{16'h0014}}}, 16'(120 / ((t_lb[i] ? 1 : 2) * 2)),
               16'(60 / (t_ddr[i] ? 1 : 2)));
        `CHK({csb_ratio, memory_ratio}, {e_csb, e_mem});
        if (i == 0) begin
            apb(1'b0, 12'h000, 32'h0000_0000);
            `CHK(rd, 32'h0000_01FF);
            apb(1'b0, 12'h004, 32'h0000_0000);
            `CHK(rd[3:0], 4'h2);
            apb(1'b1, 12'h000, 32'h0000_0139);
            apb(1'b1, 12'h004, 32'h0000_0004);
            apb(1'b1, 12'h008, 32'hFFFF_FFFF);
            apb(1'b0, 12'h008, 32'h0000_0000);
            `CHK(rd[7:0], e_csb);
            counts(16'h003C, {16'h003C, 16'h0000, 16'h0014, 16'h001E, 16'h003C}, 16'h000F,
                   16'h003C);
            apb(1'b0, 12'h010, 32'h0000_0000);
            `CHK({er, rd}, {1'b1, 32'h0000_0000});
            apb(1'b1, 12'h004, 32'h0000_0001);
            counts(16'h003C, {16'h003C, 16'h0000, 16'h0014, 16'h001E, 16'h003C}, 16'h001E,
                   16'h003C);
        end
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        clr = 1'b0;
        core_tdo = 1'b0;
        reset_config_word_low = 32'h0000_0000;
        hard_reset_option_pin = 1'b0;
        input_clock_predivide_pin = 1'b0;
        pci_host_mode_pin = 1'b0;
        for (int i = 0; i < 5; i++) run_strap(i);
        finish_test;
    end
    initial begin
        #300000;
        failures++;
        finish_test;
    end
endmodule
bind ccr_top ccr_props u_props (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .core_tdo(core_tdo), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .pci_sync_out_oe_n(pci_sync_out_oe_n), .csb_ratio(csb_ratio),
    .memory_ratio(memory_ratio), .clocks_valid(clocks_valid), .mult_reserved(mult_reserved),
    .csb_tick(csb_tick), .memory_clk_tick(memory_clk_tick),
    .local_bus_unit_tick(local_bus_unit_tick), .memory_bus_clock_out(memory_bus_clock_out),
    .memory_bus_clock_out_n(memory_bus_clock_out_n), .local_bus_clock_out(local_bus_clock_out),
    .local_bus_sync_out(local_bus_sync_out), .pci_sync_out(pci_sync_out));
`default_nettype wire
